/* File: hdl/spi_slave_pkg.sv */
package spi_slave_pkg;
  // serial byte geometry
  localparam int BYTE_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] CNT_RESET = 3'h0;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] TX_BUF_RESET = 8'h00;
  localparam logic [7:0] RX_DATA_RESET = 8'h00;

  // transfer-mode field: bit 1 polarity, bit 0 phase
  localparam int MODE_PHA = 0;
  localparam int MODE_POL = 1;
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;

  // bit-order select values
  localparam logic ORDER_MSB_FIRST = 1'h0;
  localparam logic ORDER_LSB_FIRST = 1'h1;

  // flag clear strobe positions
  localparam int CLR_W = 4;
  localparam int CLR_DONE = 0;
  localparam int CLR_WRITE_COLLISION_FLAG = 1;
  localparam int CLR_RXC = 2;
  localparam int CLR_TXC = 3;

  // synchroniser lanes and their reset levels (ss deselected, sck low)
  localparam int PIN_W = 3;
  localparam int PIN_MOSI = 0;
  localparam int PIN_SS = 1;
  localparam int PIN_SCK = 2;
  localparam logic [2:0] PIN_RESET = 3'h2;

  // flag reset levels
  localparam logic FLAG_RESET = 1'h0;
  localparam logic EMPTY_RESET = 1'h1;
  localparam logic MISO_RESET = 1'h0;

  typedef enum logic {ST_IDLE, ST_ACTIVE} slave_state_e;
endpackage : spi_slave_pkg

/* File: hdl/spi_pin_if.sv */
`timescale 1ns/1ps
// synchronised link pins and sck edge strobes
interface spi_pin_if;
  logic ss_n;
  logic mosi;
  logic sck_rise;
  logic sck_fall;
  modport sync_side (output ss_n, output mosi, output sck_rise, output sck_fall);
  modport engine_side (input ss_n, input mosi, input sck_rise, input sck_fall);
endinterface : spi_pin_if

/* File: hdl/spi_pin_sync.sv */
`timescale 1ns/1ps
module spi_pin_sync
  import spi_slave_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  spi_pin_if.sync_side pins
);
  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] meta;
  logic [PIN_W-1:0] stab;
  logic sck_prev;

  // pin lanes in a fixed order
  assign raw[PIN_MOSI] = mosi_in;
  assign raw[PIN_SS] = ss_n_in;
  assign raw[PIN_SCK] = sck_in;

  // two-stage synchroniser per pin
  genvar g;
  generate
    for (g = 0; g < PIN_W; g++)
    begin : g_lane
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          meta[g] <= PIN_RESET[g];
          stab[g] <= PIN_RESET[g];
        end
        else if (clk_en_in)
        begin
          meta[g] <= raw[g];
          stab[g] <= meta[g];
        end
      end
    end
  endgenerate

  // history of the stable sck for edge detection
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sck_prev <= PIN_RESET[PIN_SCK];
    else if (clk_en_in)
      sck_prev <= stab[PIN_SCK];
  end

  // edges seen only on synchronised levels
  assign pins.ss_n = stab[PIN_SS];
  assign pins.mosi = stab[PIN_MOSI];
  assign pins.sck_rise = stab[PIN_SCK] & ~sck_prev;
  assign pins.sck_fall = ~stab[PIN_SCK] & sck_prev;
endmodule : spi_pin_sync

/* File: hdl/spi_slave_mode_engine.sv */
// Summary of operation
// - chip select, mosi, sck are inputs only
// - selected slave shifts miso when pin output
// - deselected: ignore data, miso high impedance
// - deselect resets state and counter, drops data
// - normal mode idle while deselected, writes allowed
// - first sck pulse starts shifting loaded byte
// - normal mode: done flag per shifted byte
// - normal mode premature write discarded, collision flag
// - buffer enable selects buffered slave mode
// - no wait: writes buffered, first byte dummy
// - transfer end moves buffer into shift register
// - write to full buffer is lost
// - empty flag clears on write, sets on copy
// - receive flag one cycle after empty flag
// - complete flag one later, when all sent
// - wait mode: first deselected write loads shift register
// - four polarity/phase combinations via two bits
// - change on one edge, sample opposite
// - mode codes fix sample and setup edges
// - bit order 0 msb first, 1 lsb
`timescale 1ns/1ps
module spi_slave_mode_engine
  import spi_slave_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic miso_dir_in,
  input wire logic buffer_mode_enable_in,
  input wire logic buffer_wait_receive_in,
  input wire logic bit_order_select_in,
  input wire logic [1:0] transfer_mode_in,
  input wire logic data_wr_in,
  input wire logic [7:0] data_wdata_in,
  input wire logic [CLR_W-1:0] flag_clear_in,
  output logic [7:0] rx_data_out,
  output logic busy_out,
  output logic transfer_done_flag_out,
  output logic write_collision_flag_out,
  output logic tx_buffer_empty_flag_out,
  output logic receive_complete_flag_out,
  output logic transfer_complete_flag_out
);
  spi_pin_if pins();

  slave_state_e state;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx_buf;
  logic [7:0] shift_in;
  logic out_bit;
  logic miso_q;
  logic sample_edge;
  logic setup_edge;
  logic late_sample;
  logic active;
  logic busy;
  logic byte_done;
  logic norm_wr;
  logic collision;
  logic buf_wr_ok;
  logic direct_wr;
  logic copy_pending;
  logic primed;
  logic dre;
  logic done_d1;
  logic done_d2;
  logic empty_d1;
  logic empty_d2;
  logic done_flag;
  logic write_collision_flag_flag;
  logic rxc_flag;
  logic txc_flag;

  // pins only read, never driven
  spi_pin_sync u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clk_en_in(clk_en_in),
    .sck_in(sck_in),
    .ss_n_in(ss_n_in),
    .mosi_in(mosi_in),
    .pins(pins)
  );

  // sample on leading edge for phase 0, trailing for phase 1
  assign late_sample = transfer_mode_in[MODE_POL] ^ transfer_mode_in[MODE_PHA];
  // data changes on the edge opposite the sample edge
  assign sample_edge = late_sample ? pins.sck_fall : pins.sck_rise;
  assign setup_edge = late_sample ? pins.sck_rise : pins.sck_fall;

  // selected only while chip select is low right now
  assign active = (state == ST_ACTIVE) && !pins.ss_n;
  assign busy = active && (bit_cnt != CNT_RESET);
  assign byte_done = active && sample_edge && (bit_cnt == LAST_BIT);

  // shift direction and outgoing bit by bit order
  assign shift_in = bit_order_select_in ? {pins.mosi, shreg[7:1]} : {shreg[6:0], pins.mosi};
  assign out_bit = bit_order_select_in ? shreg[0] : shreg[7];

  // data write steering per mode
  assign norm_wr = data_wr_in && !buffer_mode_enable_in && !busy;
  assign collision = data_wr_in && !buffer_mode_enable_in && busy;
  assign buf_wr_ok = data_wr_in && buffer_mode_enable_in && dre;
  assign direct_wr = buf_wr_ok && buffer_wait_receive_in && pins.ss_n && !primed;

  // selection state machine
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state <= ST_IDLE;
    else if (clk_en_in)
    begin
      unique case (state)
        ST_IDLE:
          if (!pins.ss_n)
            state <= ST_ACTIVE;
        ST_ACTIVE:
          if (pins.ss_n)
            state <= ST_IDLE;
      endcase
    end
  end

  // bit counter, cleared at once by deselect
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      bit_cnt <= CNT_RESET;
    else if (clk_en_in)
    begin
      if (!active)
        bit_cnt <= CNT_RESET;
      else if (sample_edge)
        bit_cnt <= bit_cnt + 3'h1; // wraps after the last bit
    end
  end

  // shift register: sampling, buffer copy and direct loads
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      shreg <= SHIFT_RESET;
    else if (clk_en_in)
    begin
      if (byte_done && buffer_mode_enable_in && !dre)
        shreg <= tx_buf;
      else if (active && sample_edge)
        shreg <= shift_in;
      else if (copy_pending)
        shreg <= tx_buf;
      else if (norm_wr)
        shreg <= data_wdata_in;
    end
  end

  // transmit buffer, written only while empty
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      tx_buf <= TX_BUF_RESET;
    else if (clk_en_in && buf_wr_ok)
      tx_buf <= data_wdata_in;
  end

  // wait-for-receive: first deselected write copied next cycle
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      copy_pending <= FLAG_RESET;
      primed <= FLAG_RESET;
    end
    else if (clk_en_in)
    begin
      copy_pending <= direct_wr;
      if (!buffer_mode_enable_in)
        primed <= FLAG_RESET;
      else if (copy_pending)
        primed <= 1'h1;
      else if (byte_done && dre)
        primed <= FLAG_RESET; // shift register sent, nothing queued
    end
  end

  // buffer-empty flag: clear on write, set on copy
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      dre <= EMPTY_RESET;
    else if (clk_en_in)
    begin
      if (!buffer_mode_enable_in)
        dre <= EMPTY_RESET;
      else if (buf_wr_ok)
        dre <= FLAG_RESET;
      else if (copy_pending || byte_done)
        dre <= 1'h1;
    end
  end

  // flag pipeline after a buffered transfer
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      done_d1 <= FLAG_RESET;
      done_d2 <= FLAG_RESET;
      empty_d1 <= FLAG_RESET;
      empty_d2 <= FLAG_RESET;
    end
    else if (clk_en_in)
    begin
      done_d1 <= byte_done && buffer_mode_enable_in;
      empty_d1 <= dre; // nothing queued behind the sent byte
      done_d2 <= done_d1;
      empty_d2 <= empty_d1;
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      done_flag <= FLAG_RESET;
      write_collision_flag_flag <= FLAG_RESET;
      rxc_flag <= FLAG_RESET;
      txc_flag <= FLAG_RESET;
    end
    else if (clk_en_in)
    begin
      if (byte_done && !buffer_mode_enable_in)
        done_flag <= 1'h1;
      else if (flag_clear_in[CLR_DONE])
        done_flag <= FLAG_RESET;
      if (collision)
        write_collision_flag_flag <= 1'h1;
      else if (flag_clear_in[CLR_WRITE_COLLISION_FLAG])
        write_collision_flag_flag <= FLAG_RESET;
      if (done_d1)
        rxc_flag <= 1'h1;
      else if (flag_clear_in[CLR_RXC])
        rxc_flag <= FLAG_RESET;
      if (done_d2 && empty_d2)
        txc_flag <= 1'h1;
      else if (flag_clear_in[CLR_TXC])
        txc_flag <= FLAG_RESET;
    end
  end

  // received byte, only whole bytes kept
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rx_data_out <= RX_DATA_RESET;
    else if (clk_en_in && byte_done)
      rx_data_out <= shift_in; // partial bytes never land here
  end

  // miso data flop, updated on setup edges
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      miso_q <= MISO_RESET;
    else if (clk_en_in)
    begin
      if (!active || (bit_cnt == CNT_RESET) || setup_edge)
        miso_q <= out_bit;
    end
  end

  // outputs
  assign miso_out = miso_q;
  assign miso_oe_out = miso_dir_in && !pins.ss_n;
  assign busy_out = busy;
  assign transfer_done_flag_out = done_flag;
  assign write_collision_flag_out = write_collision_flag_flag;
  assign tx_buffer_empty_flag_out = dre;
  assign receive_complete_flag_out = rxc_flag;
  assign transfer_complete_flag_out = txc_flag;

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in || !clk_en_in);

  sequence s_buf_done;
    byte_done && buffer_mode_enable_in;
  endsequence

  sequence s_empty_then_rxc;
    dre ##1 rxc_flag;
  endsequence

  property p_miso_hiz;
    miso_oe_out == (miso_dir_in && !pins.ss_n);
  endproperty
  a_miso_hiz: assert property (p_miso_hiz) else $error("miso enable wrong for chip select");

  property p_deselect_reset;
    pins.ss_n |=> (bit_cnt == CNT_RESET) && (state == ST_IDLE) && !busy_out;
  endproperty
  a_deselect_reset: assert property (p_deselect_reset) else $error("deselect did not reset counter");

  property p_idle_no_done;
    pins.ss_n |-> !byte_done ##1 $stable(rx_data_out);
  endproperty
  a_idle_no_done: assert property (p_idle_no_done) else $error("byte completed while deselected");

  property p_done_flag;
    byte_done && !buffer_mode_enable_in |=> transfer_done_flag_out && !receive_complete_flag_out[*1];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag not set after byte");

  property p_collision;
    data_wr_in && !buffer_mode_enable_in && busy && !sample_edge |=> write_collision_flag_out && $stable(shreg);
  endproperty
  a_collision: assert property (p_collision) else $error("premature write not rejected");

  property p_full_write_lost;
    data_wr_in && buffer_mode_enable_in && !dre |=> $stable(tx_buf);
  endproperty
  a_full_write_lost: assert property (p_full_write_lost) else $error("full buffer was overwritten");

  property p_write_clears_empty;
    buf_wr_ok |=> !tx_buffer_empty_flag_out;
  endproperty
  a_write_clears_empty: assert property (p_write_clears_empty) else $error("empty flag not cleared");

  property p_rxc_after_empty;
    s_buf_done |=> s_empty_then_rxc;
  endproperty
  a_rxc_after_empty: assert property (p_rxc_after_empty) else $error("receive flag timing wrong");

  property p_txc_timing;
    s_buf_done ##0 dre |=> ##2 transfer_complete_flag_out;
  endproperty
  a_txc_timing: assert property (p_txc_timing) else $error("transfer complete flag late");

  property p_buffer_copy;
    byte_done && buffer_mode_enable_in && !dre |=> shreg == $past(tx_buf);
  endproperty
  a_buffer_copy: assert property (p_buffer_copy) else $error("buffer not moved to shift register");

  property p_direct_load;
    direct_wr |=> ##1 shreg == $past(data_wdata_in, 2);
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("wait-mode write not in shift register");

  property p_bit_order;
    !active |=> miso_out == ($past(bit_order_select_in) ? $past(shreg[0]) : $past(shreg[7]));
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("first miso bit wrong for order");
endmodule : spi_slave_mode_engine

/* File: test/spi_master_model.sv */
`timescale 1ns/1ps
// far-side master; sck stands still between frames
module spi_master_model
(
  input wire logic link_clk_in,
  input wire logic miso_in,
  input wire logic miso_oe_in,
  output logic sck_out,
  output logic ss_n_out,
  output logic mosi_out
);
  logic last_miso;
  // idle pins at time zero
  initial
  begin
    sck_out = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
    last_miso = 1'b0;
  end
  // four link clocks per phase, well over two peripheral clocks
  task automatic half;
    repeat (4) @(posedge link_clk_in);
  endtask : half
  // one frame; a short count leaves the byte unfinished
  task automatic xfer(input logic [1:0] mode, input logic lsb, input logic [7:0] tx, input int nbits,
    output logic [7:0] rx);
    int k;
    rx = 8'h00;
    sck_out = mode[1]; // idle level
    half();
    ss_n_out = 1'b0;
    half();
    for (int i = 0; i < nbits; i++)
    begin
      k = lsb ? i : 7 - i;
      if (mode[0])
        sck_out = ~sck_out;
      mosi_out = tx[k]; // setup edge
      half();
      sck_out = ~sck_out;
      rx[k] = miso_oe_in ? miso_in : ~last_miso; // sample edge; undriven pin reads inverted
      last_miso = rx[k];
      half();
      if (!mode[0])
        sck_out = ~sck_out;
    end
    half();
    ss_n_out = 1'b1;
    mosi_out = ~mosi_out;
    half();
  endtask : xfer
endmodule : spi_master_model

/* File: test/spi_slave_mode_engine_tb_top.sv */
`timescale 1ns/1ps
module spi_slave_mode_engine_tb_top
  import spi_slave_pkg::*;
;
  logic clk, link_clk, resetn, miso_dir, buf_en, buf_wait, order, wr;
  logic [1:0] mode;
  logic [7:0] wdata, rx_data;
  logic [CLR_W-1:0] clr;
  logic sck, ss_n, mosi, miso, miso_oe, busy, done, wcol, empty, rxc, txc;
  int miscompares = 0;
  int comparisons = 0;
  // both clocks, unrelated in phase
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  spi_slave_mode_engine dut (.clk_in(clk), .resetn_in(resetn), .clk_en_in(1'b1), .sck_in(sck),
    .ss_n_in(ss_n), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .miso_dir_in(miso_dir),
    .buffer_mode_enable_in(buf_en), .buffer_wait_receive_in(buf_wait), .bit_order_select_in(order),
    .transfer_mode_in(mode), .data_wr_in(wr), .data_wdata_in(wdata), .flag_clear_in(clr),
    .rx_data_out(rx_data), .busy_out(busy), .transfer_done_flag_out(done),
    .write_collision_flag_out(wcol), .tx_buffer_empty_flag_out(empty),
    .receive_complete_flag_out(rxc), .transfer_complete_flag_out(txc));
  spi_master_model m (.link_clk_in(link_clk), .miso_in(miso), .miso_oe_in(miso_oe), .sck_out(sck),
    .ss_n_out(ss_n), .mosi_out(mosi));
  // verdict and end of run
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // compare helpers
  task automatic chk1(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8
  // one-cycle strobes
  task automatic wr_byte(input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_byte
  task automatic clear_all;
    @(negedge clk);
    clr = 4'hF;
    @(negedge clk);
    clr = 4'h0;
  endtask : clear_all
  // every mode and both bit orders, write while deselected
  task automatic t_normal;
    logic [7:0] got;
    for (int i = 0; i < 4; i++)
    begin
      order = i[0];
      mode = 2'(i);
      wr_byte({4'(i), 4'h6});
      m.xfer(mode, order, {4'h9, 4'(i)}, 8, got);
      chk8(got, {4'(i), 4'h6}, "miso byte");
      repeat (4) @(negedge clk);
      chk8(rx_data, {4'h9, 4'(i)}, "mosi byte");
      chk1(done, 1'b1, "done flag");
      chk1(miso_oe, 1'b0, "miso released");
      clear_all();
    end
    $display("end t_normal");
  endtask : t_normal
  // write during a byte is dropped
  task automatic t_collision;
    logic [7:0] got;
    order = 1'b0;
    mode = MODE_0;
    wr_byte(8'hA7);
    fork
      m.xfer(mode, order, 8'h5B, 8, got);
      begin
        repeat (40) @(negedge clk);
        chk1(busy, 1'b1, "busy mid byte");
        wr_byte(8'h18);
      end
    join
    chk8(got, 8'hA7, "collided byte");
    chk1(wcol, 1'b1, "collision flag");
    clear_all();
    $display("end t_collision");
  endtask : t_collision
  // deselect mid byte drops it
  task automatic t_abort;
    logic [7:0] got;
    wr_byte(8'h66);
    m.xfer(mode, order, 8'hF0, 4, got);
    repeat (4) @(negedge clk);
    chk8(rx_data, 8'h5B, "rx after abort");
    chk1(done, 1'b0, "done after abort");
    chk1(busy, 1'b0, "busy after abort");
    chk1(miso_oe, 1'b0, "miso after abort");
    wr_byte(8'h3A);
    m.xfer(mode, order, 8'hC5, 8, got);
    chk8(got, 8'h3A, "byte after abort");
    clear_all();
    $display("end t_abort");
  endtask : t_abort
  // buffered, no wait: dummy first, lost write, flag order
  task automatic t_buf_nowait;
    logic [7:0] got;
    int n;
    buf_en = 1'b1;
    buf_wait = 1'b0;
    wr_byte(8'h43);
    chk1(empty, 1'b0, "empty after write");
    fork
      m.xfer(mode, order, 8'h11, 8, got);
      begin
        n = 0;
        while (empty !== 1'b1 && n < 2000)
        begin
          @(negedge clk);
          n++;
        end
        if (n >= 2000)
        begin
          miscompares++;
          $display("[ERR] %0t empty flag wait", $time);
          end_of_test();
        end
        chk1(rxc, 1'b0, "rxc early");
        @(negedge clk);
        chk1(rxc, 1'b1, "rxc late");
        @(negedge clk);
        chk1(txc, 1'b0, "txc with full buffer");
      end
    join
    chk8(got, 8'hC5, "dummy byte");
    wr_byte(8'h44);
    wr_byte(8'h45);
    chk1(empty, 1'b0, "empty while full");
    m.xfer(mode, order, 8'h22, 8, got);
    chk8(got, 8'h43, "buffered byte");
    chk1(txc, 1'b0, "txc after refill");
    m.xfer(mode, order, 8'h33, 8, got);
    chk8(got, 8'h44, "lost write skipped");
    repeat (4) @(negedge clk);
    chk1(txc, 1'b1, "txc all sent");
    chk8(rx_data, 8'h33, "buffered rx");
    clear_all();
    $display("end t_buf_nowait");
  endtask : t_buf_nowait
  // buffered, wait for receive: first write goes straight out
  task automatic t_buf_wait;
    logic [7:0] got;
    buf_wait = 1'b1;
    wr_byte(8'h5A);
    repeat (3) @(negedge clk);
    chk1(empty, 1'b1, "empty after prime");
    wr_byte(8'hA5);
    chk1(empty, 1'b0, "buffer filled");
    m.xfer(mode, order, 8'h0F, 8, got);
    chk8(got, 8'h5A, "primed byte");
    m.xfer(mode, order, 8'hF1, 8, got);
    chk8(got, 8'hA5, "second byte");
    $display("end t_buf_wait");
  endtask : t_buf_wait
  // main sequence
  initial
  begin
    resetn = 1'b0;
    miso_dir = 1'b1;
    buf_en = 1'b0;
    buf_wait = 1'b0;
    order = 1'b0;
    mode = MODE_0;
    wr = 1'b0;
    wdata = 8'h00;
    clr = 4'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    chk1(empty, 1'b1, "empty reset");
    chk1(miso_oe, 1'b0, "miso reset");
    chk8(rx_data, 8'h00, "rx reset");
    t_normal();
    t_collision();
    t_abort();
    t_buf_nowait();
    t_buf_wait();
    end_of_test();
  end
endmodule : spi_slave_mode_engine_tb_top
